// ### core/lpd_pkg.sv
// shared constants of the sixteen channel led pwm driver
package lpd_pkg;
	// clock and pwm timing
	localparam int          CLK_HZ        = 25000000;
	localparam int          IND_PWM_HZ    = 97000;
	localparam int          DIM_PWM_HZ    = 190;
	localparam int          BLINK_MAX_HZ  = 24;
	localparam int          PWM_STEPS     = 256;
	// cycles per counter step, rounded down, never below one
	localparam int          IND_STEP_RAW  = CLK_HZ / (IND_PWM_HZ * PWM_STEPS);
	localparam int          IND_STEP      = (IND_STEP_RAW < 1) ? 1 : IND_STEP_RAW;
	localparam int          DIM_STEP      = CLK_HZ / (DIM_PWM_HZ * PWM_STEPS);
	localparam int          BLINK_STEP    = CLK_HZ / (BLINK_MAX_HZ * PWM_STEPS);
	localparam int          GRP_PRE_W     = 21;
	// register indices, byte address is four times the index
	localparam logic [4:0]  REG_MODE_ADDR = 5'h00;
	localparam logic [4:0]  REG_MODE_OUT  = 5'h01;
	localparam logic [4:0]  REG_DUTY0     = 5'h02;
	localparam logic [4:0]  REG_GRP_DUTY  = 5'h12;
	localparam logic [4:0]  REG_GRP_RATE  = 5'h13;
	localparam logic [4:0]  REG_SEL0      = 5'h14;
	localparam logic [4:0]  REG_SUB1      = 5'h18;
	localparam logic [4:0]  REG_GCALL     = 5'h1B;
	localparam logic [4:0]  REG_STATUS    = 5'h1C;
	localparam int          NREG          = 28;
	// field positions
	localparam int          GCALL_EN_BIT  = 0;
	localparam int          SUB_EN_LSB    = 1;
	localparam int          ON_ACK_BIT    = 3;
	localparam int          BLINK_BIT     = 5;
	localparam int          AI_INC_BIT    = 2;
	// reset values
	localparam logic [7:0]  RST_MODE_ADDR = 8'h01;
	localparam logic [7:0]  RST_MODE_OUT  = 8'h00;
	localparam logic [7:0]  RST_DUTY      = 8'h00;
	localparam logic [7:0]  RST_GRP_DUTY  = 8'hFF;
	localparam logic [7:0]  RST_GRP_RATE  = 8'h00;
	localparam logic [7:0]  RST_SEL       = 8'h00;
	localparam logic [7:0]  RST_SUB1      = 8'hE2;
	localparam logic [7:0]  RST_SUB2      = 8'hE4;
	localparam logic [7:0]  RST_SUB3      = 8'hE8;
	localparam logic [7:0]  RST_GCALL     = 8'hE0;
	// per output selection codes
	localparam logic [1:0]  SEL_OFF       = 2'h0;
	localparam logic [1:0]  SEL_ON        = 2'h1;
	localparam logic [1:0]  SEL_IND       = 2'h2;
	localparam logic [1:0]  SEL_GRP       = 2'h3;
	// link to core handshake kinds
	localparam logic [1:0]  KIND_ADDR     = 2'h0;
	localparam logic [1:0]  KIND_WRITE    = 2'h1;
	localparam logic [1:0]  KIND_READ     = 2'h2;
	localparam logic [1:0]  KIND_STOP     = 2'h3;
	localparam logic [6:0]  SOFT_RESET_CALL_ADDR    = 7'h03;
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ### core/lpd_i2c_link.sv
// byte level i2c slave running on the link clock
module lpd_i2c_link
(
	// link clock and raw reset
	input  wire logic       link_clk,
	input  wire logic       aresetn,
	// bus pins, open drain
	input  wire logic       scl_i,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_oe,
	// handshake toward the core
	output logic            req_tgl,
	output logic [1:0]      kind,
	output logic [7:0]      wdata,
	input  wire logic       ack_tgl,
	input  wire logic [7:0] rep_data,
	input  wire logic       rep_match
);
	typedef enum logic [3:0] {
		L_IDLE = 4'h0, L_ADDR = 4'h1, L_AWAIT = 4'h3, L_AACK = 4'h2,
		L_WR = 4'h6, L_WWAIT = 4'h7, L_WACK = 4'h5,
		L_RFETCH = 4'h4, L_RD = 4'hC, L_RACK = 4'hD
	} lpd_link_st_t;

	typedef struct packed {
		logic         scl_s1, scl_s2, scl_d;
		logic         sda_s1, sda_s2, sda_d;
		logic         ack_s1, ack_s2;
		lpd_link_st_t st;
		logic [3:0]   bitcnt;
		logic [7:0]   shreg;
		logic         rw, need;
		logic [1:0]   need_kind, kind;
		logic [7:0]   wdata;
		logic         req_tgl, stop_pend, scl_oe, sda_oe;
	} lpd_link_t;

	lpd_link_t s, n;
	logic      rst_s1, rst_s2;

	// reset release is brought onto the link clock before use
	always_ff @(posedge link_clk)
	begin
		rst_s1 <= aresetn;
		rst_s2 <= rst_s1;
	end

	// next state of the slave; stretching scl holds the master while the core answers
	always_comb
	begin
		logic done, rise, fall, start, stop;
		n = s;
		n.scl_s1 = scl_i;
		n.scl_s2 = s.scl_s1;
		n.scl_d = s.scl_s2;
		n.sda_s1 = sda_i;
		n.sda_s2 = s.sda_s1;
		n.sda_d = s.sda_s2;
		n.ack_s1 = ack_tgl;
		n.ack_s2 = s.ack_s1;
		done = (s.ack_s2 == s.req_tgl);
		rise = s.scl_s2 && !s.scl_d;
		fall = !s.scl_s2 && s.scl_d;
		start = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
		stop = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;
		// one request in flight; a pending stop goes first
		if (s.stop_pend && done)
		begin
			n.req_tgl = ~s.req_tgl;
			n.kind = lpd_pkg::KIND_STOP;
			n.stop_pend = 1'b0;
		end
		else if (s.need && done)
		begin
			n.req_tgl = ~s.req_tgl;
			n.kind = s.need_kind;
			n.need = 1'b0;
		end
		// sda settles one link cycle before the stretched clock is let go, for data setup
		if (s.scl_oe && (s.st == L_AACK || s.st == L_WACK || s.st == L_RD || s.st == L_IDLE))
			n.scl_oe = 1'b0;
		if (start)
		begin
			n.st = L_ADDR;
			n.bitcnt = 4'h0;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.need = 1'b0;
		end
		else if (stop)
		begin
			n.stop_pend = (s.st != L_IDLE) || s.stop_pend;
			n.st = L_IDLE;
			n.sda_oe = 1'b0;
			n.scl_oe = 1'b0;
			n.need = 1'b0;
		end
		else
		begin
			case (s.st)
				L_ADDR, L_WR:
				begin
					if (rise)
					begin
						n.shreg = {s.shreg[6:0], s.sda_s2};
						n.bitcnt = s.bitcnt + 4'h1;
					end
					else if (fall && s.bitcnt == 4'h8)
					begin
						n.scl_oe = 1'b1;
						n.need = 1'b1;
						n.wdata = s.shreg;
						n.need_kind = (s.st == L_ADDR) ? lpd_pkg::KIND_ADDR : lpd_pkg::KIND_WRITE;
						n.st = (s.st == L_ADDR) ? L_AWAIT : L_WWAIT;
					end
				end
				L_AWAIT:
				begin
					if (!s.need && done)
					begin
						n.sda_oe = rep_match;
						n.rw = s.shreg[0];
						n.st = rep_match ? L_AACK : L_IDLE;
					end
				end
				L_AACK:
				begin
					if (fall)
					begin
						n.sda_oe = 1'b0;
						n.bitcnt = 4'h0;
						n.need = s.rw;
						n.need_kind = lpd_pkg::KIND_READ;
						n.scl_oe = s.rw;
						n.st = s.rw ? L_RFETCH : L_WR;
					end
				end
				L_WWAIT:
				begin
					if (!s.need && done)
					begin
						n.sda_oe = 1'b1;
						n.st = L_WACK;
					end
				end
				L_WACK:
				begin
					if (fall)
					begin
						n.sda_oe = 1'b0;
						n.bitcnt = 4'h0;
						n.st = L_WR;
					end
				end
				L_RFETCH:
				begin
					if (!s.need && done)
					begin
						n.shreg = rep_data;
						n.sda_oe = ~rep_data[7];
						n.bitcnt = 4'h0;
						n.st = L_RD;
					end
				end
				L_RD:
				begin
					if (rise)
						n.bitcnt = s.bitcnt + 4'h1;
					else if (fall && s.bitcnt == 4'h8)
					begin
						n.sda_oe = 1'b0;
						n.st = L_RACK;
					end
					else if (fall)
					begin
						n.shreg = {s.shreg[6:0], 1'b0};
						n.sda_oe = ~s.shreg[6];
					end
				end
				L_RACK:
				begin
					// master nack ends the read, ack asks for the next byte
					if (rise && s.sda_s2)
						n.st = L_IDLE;
					else if (rise)
						n.bitcnt = 4'h9;
					else if (fall && s.bitcnt == 4'h9)
					begin
						n.need = 1'b1;
						n.need_kind = lpd_pkg::KIND_READ;
						n.scl_oe = 1'b1;
						n.st = L_RFETCH;
					end
				end
				default:
					n.st = L_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clk)
	begin
		if (!rst_s2)
			s <= '0;
		else
			s <= n;
	end

	assign scl_oe  = s.scl_oe;
	assign sda_oe  = s.sda_oe;
	assign req_tgl = s.req_tgl;
	assign kind    = s.kind;
	assign wdata   = s.wdata;
endmodule

// ### core/lpd_top.sv
// sixteen channel led pwm driver core with axi4-lite registers
// Functional notes
// - sixteen independent 8-bit pwm outputs, 256 steps, about 97 kHz, duty zero to 99.6%.
// - shared 8-bit group pwm, 190 Hz dimming or programmable blink period.
// - each output selects off, on, own pwm, or own pwm with group.
// - active-low enable input gates all sixteen outputs together.
// - software reset call restores all registers like power-on, all leds off.
// - i2c writes update outputs per byte acknowledge or at stop; stop is default.
// - own bus address comes from seven strap inputs.
// - group call and three sub call addresses, each separately enabled.
// - after reset each duty is off and group duty is maximum.
// - pwm and blink timing derives from the 25 MHz core clock; the i2c link runs on link_clk.
// - serial control link is a fast-mode plus i2c slave up to 1 MHz.
// - outputs stay inactive throughout reset without pulses.
// - group call address resets to E0h and enabled.
// - sub call addresses reset to E2h, E4h, E8h, disabled.
// - software reset call with read direction is not acknowledged.
// - first byte after address is control: low five pointer, top three increment.
module lpd_top
(
	// core clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// i2c link, open drain, on its own clock
	input  wire logic        link_clk,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// straps and gating pin
	input  wire logic [6:0]  addr_strap,
	input  wire logic        oe_n,
	// led outputs, open drain, sink when enabled
	output logic [15:0]      led_o,
	output logic [15:0]      led_oe
);
	typedef struct packed {
		logic [6:0]                        strap_s1, strap_s2;
		logic                              oe_s1, oe_s2;
		logic                              req_s1, req_s2, ack_tgl;
		logic [7:0]                        rep_data;
		logic                              rep_match;
		logic [lpd_pkg::NREG-1:0][7:0]     regs;
		logic [15:0][7:0]                  duty_live;
		logic [31:0]                       sel_live;
		logic [4:0]                        ptr;
		logic [2:0]                        ai;
		logic                              addressed, first_byte, soft_reset_call_pend;
		logic [7:0]                        ind_pre, ind_cnt;
		logic [lpd_pkg::GRP_PRE_W-1:0]     grp_pre;
		logic [7:0]                        grp_cnt;
		logic                              aw_held, aw_bad;
		logic [4:0]                        aw_idx;
		logic                              w_held, w_en;
		logic [7:0]                        w_byte;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              rvalid;
		logic [7:0]                        rbyte;
		logic [1:0]                        rresp;
		logic [15:0]                       led_on;
	} lpd_state_t;

	localparam int IND_PERIOD = lpd_pkg::PWM_STEPS * lpd_pkg::IND_STEP;

	lpd_state_t s, n;
	logic       link_req;
	logic [1:0] link_kind;
	logic [7:0] link_wdata;
	logic       hs_ev;
	logic       grp_on;

	// register defaults, shared by reset and the software reset call
	function automatic lpd_state_t lpd_defaults(input lpd_state_t x);
		lpd_state_t y;
		y = x;
		for (int i = 0; i < lpd_pkg::NREG; i++)
			y.regs[i] = lpd_pkg::RST_DUTY;
		y.regs[lpd_pkg::REG_MODE_ADDR] = lpd_pkg::RST_MODE_ADDR;
		y.regs[lpd_pkg::REG_MODE_OUT] = lpd_pkg::RST_MODE_OUT;
		y.regs[lpd_pkg::REG_GRP_DUTY] = lpd_pkg::RST_GRP_DUTY;
		y.regs[lpd_pkg::REG_GRP_RATE] = lpd_pkg::RST_GRP_RATE;
		for (int i = 0; i < 4; i++)
			y.regs[lpd_pkg::REG_SEL0 + i] = lpd_pkg::RST_SEL;
		y.regs[lpd_pkg::REG_SUB1] = lpd_pkg::RST_SUB1;
		y.regs[lpd_pkg::REG_SUB1 + 1] = lpd_pkg::RST_SUB2;
		y.regs[lpd_pkg::REG_SUB1 + 2] = lpd_pkg::RST_SUB3;
		y.regs[lpd_pkg::REG_GCALL] = lpd_pkg::RST_GCALL;
		y.duty_live = '0;
		y.sel_live = '0;
		y.ptr = 5'h00;
		y.ai = 3'h0;
		y.addressed = 1'b0;
		y.first_byte = 1'b0;
		y.soft_reset_call_pend = 1'b0;
		y.led_on = 16'h0000;
		return y;
	endfunction

	// status is read only and sits just past the writable block
	function automatic logic [7:0] rd_byte(input lpd_state_t x, input logic [4:0] idx,
		input logic g);
		if (idx == lpd_pkg::REG_STATUS)
			return {5'h00, x.addressed, g, x.oe_s2};
		else if (idx < lpd_pkg::REG_STATUS)
			return x.regs[idx];
		else
			return 8'h00;
	endfunction

	function automatic logic [4:0] inc_ptr(input logic [4:0] p);
		return (p >= lpd_pkg::REG_STATUS - 5'h01) ? 5'h00 : p + 5'h01;
	endfunction

	lpd_i2c_link u_link
	(
		.link_clk  (link_clk),
		.aresetn   (aresetn),
		.scl_i     (scl_i),
		.scl_oe    (scl_oe),
		.sda_i     (sda_i),
		.sda_oe    (sda_oe),
		.req_tgl   (link_req),
		.kind      (link_kind),
		.wdata     (link_wdata),
		.ack_tgl   (s.ack_tgl),
		.rep_data  (s.rep_data),
		.rep_match (s.rep_match)
	);

	// link payload is stable once the synchronised toggle differs from ours
	assign hs_ev  = (s.req_s2 != s.ack_tgl);
	assign grp_on = (s.grp_cnt < s.regs[lpd_pkg::REG_GRP_DUTY]);

	always_comb
	begin
		logic                         apply, do_rst, hit, sw, och;
		logic [6:0]                   a7;
		logic [lpd_pkg::GRP_PRE_W-1:0] div;
		logic [1:0]                   sel;
		logic                         ind_on;
		n = s;
		apply = 1'b0;
		do_rst = 1'b0;
		hit = 1'b0;
		sw = 1'b0;
		a7 = link_wdata[7:1];
		och = s.regs[lpd_pkg::REG_MODE_OUT][lpd_pkg::ON_ACK_BIT];
		div = '0;
		sel = 2'h0;
		ind_on = 1'b0;
		n.strap_s1 = addr_strap;
		n.strap_s2 = s.strap_s1;
		n.oe_s1 = oe_n;
		n.oe_s2 = s.oe_s1;
		n.req_s1 = link_req;
		n.req_s2 = s.req_s1;
		// axi write: address and data are taken in either order
		if (awvalid && awready)
		begin
			n.aw_held = 1'b1;
			n.aw_idx = awaddr[6:2];
			n.aw_bad = awaddr[7] || (awaddr[6:2] >= lpd_pkg::REG_STATUS);
		end
		if (wvalid && wready)
		begin
			n.w_held = 1'b1;
			n.w_byte = wdata[7:0];
			n.w_en = wstrb[0];
		end
		if (s.aw_held && s.w_held)
		begin
			if (!s.aw_bad && s.w_en)
			begin
				n.regs[s.aw_idx] = s.w_byte;
				apply = 1'b1;
			end
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = s.aw_bad ? lpd_pkg::RESP_SLVERR : lpd_pkg::RESP_OKAY;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		// axi read
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			n.rvalid = 1'b1;
			n.rbyte = araddr[7] ? 8'h00 : rd_byte(s, araddr[6:2], grp_on);
			n.rresp = (araddr[7] || araddr[6:2] > lpd_pkg::REG_STATUS) ?
				lpd_pkg::RESP_SLVERR : lpd_pkg::RESP_OKAY;
		end
		// events from the i2c link
		if (hs_ev)
		begin
			n.ack_tgl = s.req_s2;
			n.rep_match = 1'b1;
			case (link_kind)
				lpd_pkg::KIND_ADDR:
				begin
					hit = (a7 == s.strap_s2);
					if (s.regs[lpd_pkg::REG_MODE_ADDR][lpd_pkg::GCALL_EN_BIT] &&
						a7 == s.regs[lpd_pkg::REG_GCALL][7:1])
						hit = 1'b1;
					for (int i = 0; i < 3; i++)
						if (s.regs[lpd_pkg::REG_MODE_ADDR][lpd_pkg::SUB_EN_LSB + i] &&
							a7 == s.regs[lpd_pkg::REG_SUB1 + i][7:1])
							hit = 1'b1;
					sw = (a7 == lpd_pkg::SOFT_RESET_CALL_ADDR) && !link_wdata[0];
					n.rep_match = hit || sw;
					n.addressed = hit || sw;
					n.soft_reset_call_pend = sw;
					n.first_byte = !link_wdata[0];
				end
				lpd_pkg::KIND_WRITE:
				begin
					if (s.addressed && !s.soft_reset_call_pend && s.first_byte)
					begin
						n.ptr = link_wdata[4:0];
						n.ai = link_wdata[7:5];
						n.first_byte = 1'b0;
					end
					else if (s.addressed && !s.soft_reset_call_pend)
					begin
						if (s.ptr < lpd_pkg::REG_STATUS)
							n.regs[s.ptr] = link_wdata;
						apply = och;
						if (s.ai[lpd_pkg::AI_INC_BIT])
							n.ptr = inc_ptr(s.ptr);
					end
				end
				lpd_pkg::KIND_READ:
				begin
					n.rep_data = rd_byte(s, s.ptr, grp_on);
					if (s.ai[lpd_pkg::AI_INC_BIT])
						n.ptr = inc_ptr(s.ptr);
				end
				default:
				begin
					apply = !och;
					do_rst = s.soft_reset_call_pend;
					n.addressed = 1'b0;
				end
			endcase
		end
		// copy staged values into the live pwm set
		if (apply)
		begin
			for (int i = 0; i < 16; i++)
				n.duty_live[i] = n.regs[lpd_pkg::REG_DUTY0 + i];
			n.sel_live = {n.regs[lpd_pkg::REG_SEL0 + 3], n.regs[lpd_pkg::REG_SEL0 + 2],
				n.regs[lpd_pkg::REG_SEL0 + 1], n.regs[lpd_pkg::REG_SEL0]};
		end
		if (do_rst)
			n = lpd_defaults(n);
		// individual counter: one step per divided tick, 256 steps per period
		if (s.ind_pre >= 8'(lpd_pkg::IND_STEP - 1))
		begin
			n.ind_pre = 8'h00;
			n.ind_cnt = s.ind_cnt + 8'h01;
		end
		else
			n.ind_pre = s.ind_pre + 8'h01;
		// group counter: fixed dimming step or blink step scaled by the rate value
		if (s.regs[lpd_pkg::REG_MODE_OUT][lpd_pkg::BLINK_BIT])
			div = lpd_pkg::GRP_PRE_W'((9'(s.regs[lpd_pkg::REG_GRP_RATE]) + 9'h001) *
				lpd_pkg::BLINK_STEP);
		else
			div = lpd_pkg::GRP_PRE_W'(lpd_pkg::DIM_STEP);
		if (s.grp_pre >= div - 1'b1)
		begin
			n.grp_pre = '0;
			n.grp_cnt = s.grp_cnt + 8'h01;
		end
		else
			n.grp_pre = s.grp_pre + 1'b1;
		// output selection, gated by the enable pin
		for (int i = 0; i < 16; i++)
		begin
			sel = s.sel_live[2 * i +: 2];
			ind_on = (s.ind_cnt < s.duty_live[i]);
			case (sel)
				lpd_pkg::SEL_OFF: n.led_on[i] = 1'b0;
				lpd_pkg::SEL_ON: n.led_on[i] = 1'b1;
				lpd_pkg::SEL_IND: n.led_on[i] = ind_on;
				default: n.led_on[i] = ind_on && grp_on;
			endcase
			if (s.oe_s2)
				n.led_on[i] = 1'b0;
		end
	end

	// led_on clears in reset so no output sinks during power-up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= lpd_defaults('0);
		else
			s <= n;
	end

	assign awready = !s.aw_held && !s.bvalid;
	assign wready  = !s.w_held && !s.bvalid;
	assign bvalid  = s.bvalid;
	assign bresp   = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid  = s.rvalid;
	assign rdata   = {24'h000000, s.rbyte};
	assign rresp   = s.rresp;
	assign scl_o   = 1'b0;
	assign sda_o   = 1'b0;
	assign led_o   = 16'h0000;
	assign led_oe  = s.led_on;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_sel_off: assert property (s.sel_live[1:0] == lpd_pkg::SEL_OFF |=> !s.led_on[0])
		else $error("led0 driven while selected off");
	a_sel_on: assert property ((s.sel_live[1:0] == lpd_pkg::SEL_ON) && !s.oe_s2 |=> s.led_on[0])
		else $error("led0 not driven while selected on");
	a_oe_gate: assert property (s.oe_s2 |=> s.led_on == 16'h0000)
		else $error("output driven while enable pin high");
	a_zero_duty: assert property ((s.duty_live[3] == 8'h00) && (s.sel_live[7:6] == lpd_pkg::SEL_IND)
		|=> !s.led_on[3])
		else $error("zero duty produced drive");
	a_group_mix: assert property ((s.sel_live[1:0] == lpd_pkg::SEL_GRP) && !grp_on
		|=> !s.led_on[0])
		else $error("combined mode drives with group inactive");
	a_ind_period: assert property ((s.ind_cnt == 8'h00) && (s.ind_pre == 8'h00)
		|-> ##(IND_PERIOD) (s.ind_cnt == 8'h00))
		else $error("individual pwm period wrong");
	a_reset_duty: assert property ($rose(aresetn) |-> (s.regs[lpd_pkg::REG_GRP_DUTY] == 8'hFF)
		&& (s.duty_live == '0) && (s.led_on == 16'h0000))
		else $error("reset brightness values wrong");
	a_reset_gcall: assert property ($rose(aresetn) |-> (s.regs[lpd_pkg::REG_GCALL] == 8'hE0)
		&& s.regs[lpd_pkg::REG_MODE_ADDR][0])
		else $error("group call address not reset");
	a_reset_sub: assert property ($rose(aresetn) |-> (s.regs[lpd_pkg::REG_MODE_ADDR][3:1] == 3'h0)
		&& (s.regs[lpd_pkg::REG_SUB1 + 2] == 8'hE8))
		else $error("sub call addresses not reset");
	a_soft_reset_call_read: assert property (hs_ev && (link_kind == lpd_pkg::KIND_ADDR)
		&& (link_wdata == 8'h07) && (s.strap_s2 != lpd_pkg::SOFT_RESET_CALL_ADDR)
		&& (s.regs[lpd_pkg::REG_GCALL][7:1] != lpd_pkg::SOFT_RESET_CALL_ADDR)
		&& (s.regs[lpd_pkg::REG_MODE_ADDR][3:1] == 3'h0) |=> !s.rep_match)
		else $error("software reset call acknowledged on read");
	a_soft_reset_call_done: assert property (hs_ev && (link_kind == lpd_pkg::KIND_STOP) && s.soft_reset_call_pend
		|=> (s.regs[lpd_pkg::REG_GCALL] == 8'hE0) && (s.sel_live == '0))
		else $error("software reset did not restore defaults");
	a_stop_update: assert property (hs_ev && (link_kind == lpd_pkg::KIND_STOP)
		&& !s.regs[lpd_pkg::REG_MODE_OUT][3] && !s.soft_reset_call_pend
		|=> s.duty_live[0] == s.regs[lpd_pkg::REG_DUTY0])
		else $error("outputs not updated at stop");
	a_ack_hold: assert property (hs_ev && (link_kind == lpd_pkg::KIND_WRITE) && s.addressed
		&& !s.first_byte && !s.regs[lpd_pkg::REG_MODE_OUT][3] && !(s.aw_held && s.w_held)
		|=> s.duty_live == $past(s.duty_live))
		else $error("outputs changed before stop");

	c_i2c_write: cover property (hs_ev && link_kind == lpd_pkg::KIND_WRITE && !s.first_byte);
	c_i2c_read: cover property (hs_ev && link_kind == lpd_pkg::KIND_READ);
	c_soft_reset_call: cover property (hs_ev && link_kind == lpd_pkg::KIND_STOP && s.soft_reset_call_pend);
	c_axi_write: cover property (s.aw_held && s.w_held && !s.aw_bad);
endmodule

// ### testbench/lpd_i2c_master_model.sv
// i2c bus master model driving the link of the led driver
module lpd_i2c_master_model
(
	// resolved wire levels
	input  wire logic scl_w,
	input  wire logic sda_w,
	// pull low while set
	output logic      scl_pull,
	output logic      sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;

	// lines released at start of run
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// one bit, slow clock; the slave may stretch, so wait for the wire
	task automatic bit_io(input logic b, output logic s);
		sda_pull = !b;
		#1500 scl_pull = 1'b0;
		wait (scl_w);
		#1500 s = sda_w;
		scl_pull = 1'b1;
		#200;
	endtask

	// start: data falls while clock high
	task automatic start();
		sda_pull = 1'b0;
		scl_pull = 1'b0;
		#1500 sda_pull = 1'b1;
		#1500 scl_pull = 1'b1;
	endtask

	// byte msb first, ninth clock returns the ack level
	task automatic xfer(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, nack);
	endtask

	// stop: data rises while clock high
	task automatic stop();
		sda_pull = 1'b1;
		#1500 scl_pull = 1'b0;
		#1500 sda_pull = 1'b0;
		#1500;
	endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench of the led driver over axi4-lite and i2c
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, link_clk, oe_n, ms, md, a, acc;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, d, wd;
	logic [1:0] r;
	logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] led_oe;
	int n_mismatch = 0;
	int check_count = 0;
	int n_on;
	logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h48, 8'h60, 8'h64, 8'h68, 8'h6C};
	logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'hE2, 8'hE4, 8'hE8, 8'hE0};
	wire scl_w = !(ms | scl_oe);
	wire sda_w = !(md | sda_oe);

	lpd_top i_lpd_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata({24'h0, wd}), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .link_clk(link_clk), .scl_i(scl_w),
		.scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
		.addr_strap(7'h20), .oe_n(oe_n), .led_o(), .led_oe(led_oe));
	lpd_i2c_master_model i_lpd_i2c_master_model (.scl_w(scl_w), .sda_w(sda_w),
		.scl_pull(ms), .sda_pull(md));

	// clocks, link clock unrelated in phase
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = !aclk;
	end
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = !link_clk;
	end

	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// axi write, address and data offered together, each held until taken
	task automatic wr(input logic [7:0] ad, input logic [7:0] v, output logic [1:0] rs);
		awaddr <= ad;
		wd <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		// raised after an edge so a following call never lowers and raises it at once
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	// axi read
	task automatic rd(input logic [7:0] ad, output logic [7:0] v, output logic [1:0] rs);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		v = rdata[7:0];
		rs = rresp;
		rready <= 1'b0;
	endtask

	// one i2c address call, returns the ack level
	task automatic call(input logic [7:0] b, output logic nk);
		i_lpd_i2c_master_model.start();
		i_lpd_i2c_master_model.xfer(b, nk);
		i_lpd_i2c_master_model.stop();
	endtask

	// verdict
	task automatic complete_run();
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog, the run needs about 10000 cycles
	initial
	begin
		repeat (60000) @(posedge aclk);
		n_mismatch++;
		complete_run();
	end

	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, oe_n} = 7'h0;
		{awaddr, araddr, wd} = 24'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i], d, r);
			chk("reset value", rv[i], d);
		end
		rd(8'h80, d, r);
		chk("unmapped read", 2'h2, r);
		chk("unmapped data", 8'h00, d);
		wr(8'h70, 8'h01, r);
		chk("status write", 2'h2, r);
		wr(8'h50, 8'h01, r);
		repeat (4) @(posedge aclk);
		chk("led on", 1'b1, led_oe[0]);
		oe_n <= 1'b1;
		repeat (5) @(posedge aclk);
		chk("gated off", 16'h0, led_oe);
		oe_n <= 1'b0;
		wr(8'h50, 8'h02, r);
		acc = 1'b0;
		repeat (600) @(posedge aclk) acc |= led_oe[0];
		chk("zero duty", 1'b0, acc);
		wr(8'h08, 8'h80, r);
		n_on = 0;
		repeat (512) @(posedge aclk) n_on += led_oe[0];
		chk("half duty", 32'h100, n_on);
		wr(8'h48, 8'h00, r);
		wr(8'h50, 8'h03, r);
		acc = 1'b0;
		repeat (600) @(posedge aclk) acc |= led_oe[0];
		chk("group gate", 1'b0, acc);
		i_lpd_i2c_master_model.start();
		i_lpd_i2c_master_model.xfer(8'h40, a);
		chk("own ack", 1'b0, a);
		i_lpd_i2c_master_model.xfer(8'h02, a);
		i_lpd_i2c_master_model.xfer(8'h55, a);
		i_lpd_i2c_master_model.stop();
		repeat (20) @(posedge aclk);
		rd(8'h08, d, r);
		chk("i2c duty", 8'h55, d);
		call(8'hE0, a);
		chk("group call ack", 1'b0, a);
		call(8'hE2, a);
		chk("sub call nack", 1'b1, a);
		call(8'h07, a);
		chk("reset read nack", 1'b1, a);
		wr(8'h00, 8'h03, r);
		call(8'hE2, a);
		chk("sub call ack", 1'b0, a);
		call(8'h06, a);
		chk("reset ack", 1'b0, a);
		repeat (40) @(posedge aclk);
		rd(8'h08, d, r);
		chk("soft reset duty", 8'h00, d);
		rd(8'h00, d, r);
		chk("soft reset mode", 8'h01, d);
		complete_run();
	end
endmodule
